// ===== eil_defs.svh
// Register map, field positions and fixed values of the external interrupt latch
`ifndef EIL_DEFS_SVH
`define EIL_DEFS_SVH

// Bus widths
`define EIL_ADDR_W          8
`define EIL_DATA_W          8

// Register offsets
`define EIL_REG_STATUS_CTRL 8'h1E
`define EIL_REG_EVENT_STAT  8'h20
`define EIL_REG_EVENT_MASK  8'h21

// Status/control field positions
`define EIL_BIT_PENDING     3
`define EIL_BIT_ACK         2
`define EIL_BIT_MASK        1
`define EIL_BIT_MODE        0

// Event bits of the sticky status and mask registers
`define EIL_EVENT_W         2
`define EIL_EV_LATCHED      0
`define EIL_EV_ACK_BLOCKED  1

// Reset values
`define EIL_EVENT_RESET     2'h0
`define EIL_DATA_ZERO       8'h00

// Vector locations of this interrupt, high byte first
`define EIL_VECTOR_HI_ADDR  16'hFFFA
`define EIL_VECTOR_LO_ADDR  16'hFFFB

`endif

// ===== eil_pkg.sv
// Types shared by the external interrupt latch
package eil_pkg;

  // One register bus request from the processor
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_bus_s;

  // Sensitivity of the pin
  typedef enum logic [1:0] {
    SENSE_EDGE  = 2'h1,
    SENSE_LEVEL = 2'h2
  } sense_e;

endpackage : eil_pkg

// ===== external_interrupt_latch.sv
// External interrupt latch with status/control register and sticky event interrupt
//
// Functional notes
// - Falling pin edge sets the latch always
// - Vector fetch acknowledges and clears the latch
// - Software ack write clears like vector fetch
// - Reset clears latch and sensitivity bit
// - Edge mode: request held until acknowledge
// - Level mode: clear needs ack and pin high
// - Edge mode: acknowledge clears regardless of pin
// - Later falling edge after ack latches again
// - Mask bit withholds request from priority logic
// - Pending flag reads latch state, read-only
// - Pending flag ignores the mask bit
// - Ack bit write-only, reads zero, reset clears
// - Taken request vectors through FFFA and FFFB
// - Break with clear enable: software ack clears
// - Break without clear enable: ack ignored
//
// The plain strobed port is this design's own decision.

`include "eil_defs.svh"

module external_interrupt_latch
  import eil_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  input  wire logic                      irq_pin_n,
  input  wire logic                      vector_fetch,
  input  wire logic                      break_state,
  input  wire logic                      break_clear_enable,
  input  wire reg_bus_s                  bus,
  output logic [`EIL_DATA_W-1:0]         rd_data,
  output logic                           request_out,
  output logic [15:0]                    vector_addr,
  output logic                           pin_level,
  output logic                           irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchroniser

  logic                     rst_meta;
  logic                     rst_sync;
  logic                     pin_meta;
  logic                     pin_sync;
  logic                     pin_prev;

  // Reset asserts at once and releases two edges later
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // The pin is asynchronous; only pin_sync and pin_prev are looked at by logic
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_prev <= 1'b1;
    end else begin
      pin_meta <= irq_pin_n;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode

  logic                     hit_ctrl;
  logic                     hit_ev_stat;
  logic                     hit_ev_mask;
  logic                     wr_ctrl;
  logic                     wr_ack;
  logic                     sw_ack;
  logic                     ack_blocked;

  assign hit_ctrl    = (bus.addr == `EIL_REG_STATUS_CTRL);
  assign hit_ev_stat = (bus.addr == `EIL_REG_EVENT_STAT);
  assign hit_ev_mask = (bus.addr == `EIL_REG_EVENT_MASK);
  assign wr_ctrl     = bus.wr & hit_ctrl;
  assign wr_ack      = wr_ctrl & bus.wdata[`EIL_BIT_ACK];

  // In break, the latch is protected from a software ack unless the clear enable is set
  assign sw_ack      = wr_ack & (~break_state | break_clear_enable);
  assign ack_blocked = wr_ack & break_state & ~break_clear_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Control bits

  logic                     mask_bit;
  sense_e                   sense;
  logic                     level_mode;
  logic                     next_mask;

  assign level_mode = (sense == SENSE_LEVEL);

  // Mask as it stands after this edge, so request_out drops with the bit
  assign next_mask  = wr_ctrl ? bus.wdata[`EIL_BIT_MASK] : mask_bit;

  // Mask and sensitivity are plain read/write bits, cleared by reset
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      mask_bit <= 1'b0;
      sense    <= SENSE_EDGE;
    end else if (wr_ctrl) begin
      mask_bit <= bus.wdata[`EIL_BIT_MASK];
      sense    <= bus.wdata[`EIL_BIT_MODE] ? SENSE_LEVEL : SENSE_EDGE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt latch

  logic                     fall_now;
  logic                     ack_now;
  logic                     latch;
  logic                     acked;
  logic                     next_latch;
  logic                     next_acked;

  assign fall_now = pin_prev & ~pin_sync;
  assign ack_now  = vector_fetch | sw_ack;

  // A new edge always wins over an acknowledge in the same cycle, so no
  // request is lost; in level mode the acknowledge is remembered until the
  // pin returns high, in whichever order the two happen.
  always_comb begin
    next_latch = latch;
    next_acked = acked;
    if (fall_now) begin
      next_latch = 1'b1;
      next_acked = 1'b0;
    end else if (level_mode) begin
      if (ack_now) begin
        next_acked = 1'b1;
      end
      if ((ack_now | acked) && pin_sync) begin
        next_latch = 1'b0;
        next_acked = 1'b0;
      end else if (!pin_sync && !acked && !ack_now) begin
        next_latch = 1'b1;
      end
    end else begin
      next_acked = 1'b0;
      if (ack_now) begin
        next_latch = 1'b0;
      end
    end
  end

  // Reset drops the request even if the pin is still low
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      latch <= 1'b0;
      acked <= 1'b0;
    end else begin
      latch <= next_latch;
      acked <= next_acked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the processor

  // Masked request to priority logic; vector points at the high byte
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      request_out <= 1'b0;
      vector_addr <= `EIL_VECTOR_HI_ADDR;
      pin_level   <= 1'b1;
    end else begin
      request_out <= next_latch & ~next_mask;
      vector_addr <= `EIL_VECTOR_HI_ADDR;
      pin_level   <= pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events and interrupt output

  logic [`EIL_EVENT_W-1:0]  ev_stat;
  logic [`EIL_EVENT_W-1:0]  ev_mask;
  logic [`EIL_EVENT_W-1:0]  ev_set;
  logic [`EIL_EVENT_W-1:0]  ev_clr;
  logic [`EIL_EVENT_W-1:0]  next_ev_stat;
  logic [`EIL_EVENT_W-1:0]  next_ev_mask;

  assign ev_set = {ack_blocked, fall_now};
  assign ev_clr = (bus.wr & hit_ev_stat) ? bus.wdata[`EIL_EVENT_W-1:0] : `EIL_EVENT_RESET;

  // Set beats write-one-to-clear so an event in the clearing cycle survives
  assign next_ev_stat = (ev_stat & ~ev_clr) | ev_set;
  assign next_ev_mask = (bus.wr && hit_ev_mask) ? bus.wdata[`EIL_EVENT_W-1:0] : ev_mask;

  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      ev_stat <= `EIL_EVENT_RESET;
    end else begin
      ev_stat <= next_ev_stat;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      ev_mask <= `EIL_EVENT_RESET;
    end else if (bus.wr && hit_ev_mask) begin
      ev_mask <= bus.wdata[`EIL_EVENT_W-1:0];
    end
  end

  // Level output; a mask bit of 1 enables its event here
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(next_ev_stat & next_ev_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the read strobe

  logic [`EIL_DATA_W-1:0]   next_rd_data;

  // Pending flag shows the latch whatever the mask; ack reads as zero
  always_comb begin
    next_rd_data = `EIL_DATA_ZERO;
    if (bus.rd) begin
      if (hit_ctrl) begin
        next_rd_data[`EIL_BIT_PENDING] = latch;
        next_rd_data[`EIL_BIT_ACK]     = 1'b0;
        next_rd_data[`EIL_BIT_MASK]    = mask_bit;
        next_rd_data[`EIL_BIT_MODE]    = level_mode;
      end else if (hit_ev_stat) begin
        next_rd_data[`EIL_EVENT_W-1:0] = ev_stat;
      end else if (hit_ev_mask) begin
        next_rd_data[`EIL_EVENT_W-1:0] = ev_mask;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      rd_data <= `EIL_DATA_ZERO;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // A falling edge latches the request on the next edge
  property p_edge_sets;
    @(posedge sys_clk) disable iff (!rst_sync)
      fall_now |=> latch;
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("falling edge did not set the latch");

  // Vector fetch in edge mode clears the latch
  property p_fetch_clears;
    @(posedge sys_clk) disable iff (!rst_sync)
      (vector_fetch && !level_mode && !fall_now) |=> !latch;
  endproperty
  a_fetch_clears: assert property (p_fetch_clears)
    else $error("vector fetch did not clear the latch");

  // Accepted software ack in edge mode clears even with pin low
  property p_sw_ack_clears;
    @(posedge sys_clk) disable iff (!rst_sync)
      (wr_ack && !break_state && !level_mode && !fall_now) |=> !latch;
  endproperty
  a_sw_ack_clears: assert property (p_sw_ack_clears)
    else $error("software ack did not clear the latch");

  // Edge mode request holds with no acknowledge
  property p_edge_holds;
    @(posedge sys_clk) disable iff (!rst_sync)
      (latch && !level_mode && !vector_fetch && !wr_ctrl) |=> latch;
  endproperty
  a_edge_holds: assert property (p_edge_holds)
    else $error("edge mode request dropped without acknowledge");

  // Level mode: request stays pending while the pin is low
  property p_level_low_holds;
    @(posedge sys_clk) disable iff (!rst_sync)
      (latch && level_mode && !pin_sync && !wr_ctrl) |=> latch;
  endproperty
  a_level_low_holds: assert property (p_level_low_holds)
    else $error("level request cleared while pin low");

  // Level mode: a remembered or fresh ack with the pin high clears
  property p_level_release;
    @(posedge sys_clk) disable iff (!rst_sync)
      (level_mode && (acked || ack_now) && pin_sync) |=>
      !latch;
  endproperty
  a_level_release: assert property (p_level_release)
    else $error("level request not cleared after ack and pin high");

  // An edge after an ack write latches a new request
  property p_edge_after_ack;
    @(posedge sys_clk) disable iff (!rst_sync)
      wr_ack ##[1:8] fall_now |=> latch;
  endproperty
  a_edge_after_ack: assert property (p_edge_after_ack)
    else $error("edge after ack was lost");

  // Request reaches priority logic exactly when latched and unmasked
  property p_mask_withholds;
    @(posedge sys_clk) disable iff (!rst_sync)
      request_out == (latch && !mask_bit);
  endproperty
  a_mask_withholds: assert property (p_mask_withholds)
    else $error("request out of step with latch and mask");

  // Pending flag reads the latch, unmasked or not
  property p_pending_reads;
    @(posedge sys_clk) disable iff (!rst_sync)
      (bus.rd && hit_ctrl) |=> rd_data[`EIL_BIT_PENDING] == $past(latch);
  endproperty
  a_pending_reads: assert property (p_pending_reads)
    else $error("pending flag does not match latch");

  // Ack bit always reads back zero
  property p_ack_reads_zero;
    @(posedge sys_clk) disable iff (!rst_sync)
      (bus.rd && hit_ctrl) |=> !rd_data[`EIL_BIT_ACK];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero)
    else $error("ack bit read back as one");

  // Mask written is read back on a following read
  property p_mask_rw;
    @(posedge sys_clk) disable iff (!rst_sync)
      wr_ctrl ##1 (bus.rd && hit_ctrl && !wr_ctrl)
        |=> rd_data[`EIL_BIT_MASK] == $past(bus.wdata[`EIL_BIT_MASK], 2);
  endproperty
  a_mask_rw: assert property (p_mask_rw)
    else $error("mask bit not read back as written");

  // Vector output always names the high byte location
  property p_vector;
    @(posedge sys_clk) disable iff (!rst_sync)
      vector_fetch |-> vector_addr == `EIL_VECTOR_HI_ADDR;
  endproperty
  a_vector: assert property (p_vector)
    else $error("wrong vector location");

  // Break with clear enable: edge-mode ack write clears the latch on the next edge
  property p_break_clear;
    @(posedge sys_clk) disable iff (!rst_sync)
      (wr_ack && break_state && break_clear_enable && !level_mode && !fall_now)
        |=> !latch;
  endproperty
  a_break_clear: assert property (p_break_clear)
    else $error("ack in break with clear enable did not clear");

  // Break without clear enable: ack write leaves the latch alone
  property p_break_protect;
    @(posedge sys_clk) disable iff (!rst_sync)
      (wr_ack && break_state && !break_clear_enable && latch && !vector_fetch)
        |=> latch;
  endproperty
  a_break_protect: assert property (p_break_protect)
    else $error("protected latch cleared during break");

  // Pin level output follows the synchronised pin one edge later, three edges behind the wire
  property p_pin_level;
    @(posedge sys_clk) disable iff (!rst_sync)
      ##1 pin_level == $past(pin_sync);
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("pin level output out of step");

  // Interrupt output rises after an unmasked latch event
  property p_irq_event;
    @(posedge sys_clk) disable iff (!rst_sync)
      (fall_now && ev_mask[`EIL_EV_LATCHED]) |=> irq_out;
  endproperty
  a_irq_event: assert property (p_irq_event)
    else $error("unmasked event did not raise the interrupt");

endmodule : external_interrupt_latch

// ===== pin_source.sv
// External circuit that drives the active-low interrupt pin
module pin_source (
  input  wire logic sys_clk,
  input  wire logic drive_low,
  input  wire logic slow,
  output logic      irq_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Pin follows the command, off the clock edge; slow mode first waits for the next rising clock edge
  // so the synchroniser sees both prompt and late transitions
  initial begin
    irq_pin_n = 1'h1;
    forever begin
      @(drive_low);
      if (slow) begin
        @(posedge sys_clk);
      end
      #1;
      irq_pin_n = ~drive_low;
    end
  end
endmodule : pin_source

// ===== tb_external_interrupt_latch.sv
// Self-checking testbench of the external interrupt latch
`include "eil_defs.svh"
module tb_external_interrupt_latch
  import eil_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk;
  logic        reset_n;
  logic        pin_drive_low;
  logic        pin_slow;
  logic        irq_pin_n;
  logic        vector_fetch;
  logic        break_state;
  logic        break_clear_enable;
  reg_bus_s    bus_req;
  logic [7:0]  rd_data;
  logic        request_out;
  logic [15:0] vector_addr;
  logic        pin_level;
  logic        irq_out;
  logic [31:0] rnd_state;
  logic [7:0]  got;
  logic [7:0]  v;
  int          mismatches;
  int          cmp_count;

  ////////////////////////////////////////////////////////////////////////////
  // Design and pin driver
  external_interrupt_latch external_interrupt_latch_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .irq_pin_n(irq_pin_n),
    .vector_fetch(vector_fetch), .break_state(break_state),
    .break_clear_enable(break_clear_enable), .bus(bus_req), .rd_data(rd_data),
    .request_out(request_out), .vector_addr(vector_addr), .pin_level(pin_level),
    .irq_out(irq_out)
  );
  pin_source pin_source_i (
    .sys_clk(sys_clk), .drive_low(pin_drive_low), .slow(pin_slow), .irq_pin_n(irq_pin_n)
  );

  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // Expected status/control readback; the ack bit always reads zero
  function automatic logic [7:0] scr(input int p, input int m, input int md);
    logic [7:0] r;
    r = 8'h00;
    r[`EIL_BIT_PENDING] = p[0];
    r[`EIL_BIT_MASK] = m[0];
    r[`EIL_BIT_MODE] = md[0];
    return r;
  endfunction : scr

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'h1;
    @(posedge sys_clk);
    bus_req.wr <= 1'h0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'h1;
    @(posedge sys_clk);
    bus_req.rd <= 1'h0;
    #1;
    got = rd_data;
    chk(name, 16'(exp), 16'(got));
  endtask : rchk

  // Write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp,
                       input string name);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'h1;
    @(posedge sys_clk);
    bus_req.wr <= 1'h0;
    bus_req.rd <= 1'h1;
    @(posedge sys_clk);
    bus_req.rd <= 1'h0;
    #1;
    got = rd_data;
    chk(name, 16'(exp), 16'(got));
  endtask : wr_rd

  // Six cycles cover the slow driver lag plus the three-edge synchroniser path
  task automatic pin(input logic low);
    pin_drive_low <= low;
    cyc(6);
  endtask : pin

  task automatic ack();
    wr(`EIL_REG_STATUS_CTRL, 8'h04);
  endtask : ack

  task automatic end_of_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    cyc(5000);
    mismatches++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_n = 1'h0;
    pin_drive_low = 1'h0;
    pin_slow = 1'h0;
    vector_fetch = 1'h0;
    break_state = 1'h0;
    break_clear_enable = 1'h0;
    bus_req = '0;
    rnd_state = 32'hD070E8FC;
    mismatches = 0;
    cmp_count = 0;
    cyc(12);
    reset_n <= 1'h1;
    cyc(3);
    #1;
    // Reset values and an unmapped place
    chk("vector", 16'hFFFA, vector_addr);
    chk("pin_level", 16'h0001, 16'(pin_level));
    rchk(`EIL_REG_STATUS_CTRL, scr(0, 0, 0), "scr reset");
    rchk(`EIL_REG_EVENT_STAT, 8'h00, "event reset");
    wr(8'h55, 8'hFF);
    rchk(8'h55, 8'h00, "unmapped");
    $display("test reset done");
    // Edge capture, held request, vector fetch while pin still low
    pin(1);
    #1;
    chk("pin_level low", 16'h0000, 16'(pin_level));
    chk("request", 16'h0001, 16'(request_out));
    rchk(`EIL_REG_STATUS_CTRL, scr(1, 0, 0), "pending");
    @(posedge sys_clk);
    vector_fetch <= 1'h1;
    @(posedge sys_clk);
    vector_fetch <= 1'h0;
    cyc(1);
    #1;
    chk("request after fetch", 16'h0000, 16'(request_out));
    $display("test vector fetch done");
    // Software ack while low, then a fresh edge after an ack write
    pin(0);
    pin(1);
    ack();
    cyc(1);
    #1;
    chk("request after ack", 16'h0000, 16'(request_out));
    pin(0);
    ack();
    pin(1);
    #1;
    chk("request new edge", 16'h0001, 16'(request_out));
    $display("test ack done");
    // Masked request still visible to polling
    ack();
    wr(`EIL_REG_STATUS_CTRL, 8'h02);
    pin(0);
    pin(1);
    #1;
    chk("request masked", 16'h0000, 16'(request_out));
    rchk(`EIL_REG_STATUS_CTRL, scr(1, 1, 0), "masked pending");
    wr(`EIL_REG_STATUS_CTRL, 8'h00);
    cyc(1);
    #1;
    chk("request unmasked", 16'h0001, 16'(request_out));
    ack();
    pin(0);
    $display("test mask done");
    // Level mode: ack before pin high, then pin high before ack
    wr(`EIL_REG_STATUS_CTRL, 8'h01);
    pin(1);
    wr(`EIL_REG_STATUS_CTRL, 8'h05);
    cyc(2);
    rchk(`EIL_REG_STATUS_CTRL, scr(1, 0, 1), "level ack low");
    pin(0);
    rchk(`EIL_REG_STATUS_CTRL, scr(0, 0, 1), "level released");
    pin(1);
    pin(0);
    rchk(`EIL_REG_STATUS_CTRL, scr(1, 0, 1), "level high no ack");
    wr(`EIL_REG_STATUS_CTRL, 8'h03);
    cyc(1);
    #1;
    chk("request level masked", 16'h0000, 16'(request_out));
    wr(`EIL_REG_STATUS_CTRL, 8'h07);
    rchk(`EIL_REG_STATUS_CTRL, scr(0, 1, 1), "level acked");
    wr(`EIL_REG_STATUS_CTRL, 8'h00);
    $display("test level done");
    // Break state: ack ignored unless clear is enabled
    pin(1);
    break_state <= 1'h1;
    ack();
    rchk(`EIL_REG_STATUS_CTRL, scr(1, 0, 0), "break blocked");
    rchk(`EIL_REG_EVENT_STAT, 8'h03, "event blocked");
    @(posedge sys_clk);
    break_clear_enable <= 1'h1;
    ack();
    rchk(`EIL_REG_STATUS_CTRL, scr(0, 0, 0), "break cleared");
    @(posedge sys_clk);
    break_state <= 1'h0;
    break_clear_enable <= 1'h0;
    cyc(2);
    rchk(`EIL_REG_STATUS_CTRL, scr(0, 0, 0), "after break");
    pin(0);
    $display("test break done");
    // Sticky event interrupt: raise, mask, clear
    wr(`EIL_REG_EVENT_STAT, 8'h03);
    rchk(`EIL_REG_EVENT_STAT, 8'h00, "event cleared");
    wr(`EIL_REG_EVENT_MASK, 8'h01);
    rchk(`EIL_REG_EVENT_MASK, 8'h01, "event mask");
    chk("irq idle", 16'h0000, 16'(irq_out));
    pin(1);
    #1;
    chk("irq raised", 16'h0001, 16'(irq_out));
    wr(`EIL_REG_EVENT_MASK, 8'h00);
    cyc(1);
    #1;
    chk("irq masked", 16'h0000, 16'(irq_out));
    wr(`EIL_REG_EVENT_MASK, 8'h01);
    cyc(1);
    #1;
    chk("irq unmasked", 16'h0001, 16'(irq_out));
    wr(`EIL_REG_EVENT_STAT, 8'h01);
    cyc(1);
    #1;
    chk("irq cleared", 16'h0000, 16'(irq_out));
    ack();
    pin(0);
    $display("test events done");
    // Random control values, random driver speed, one pin pulse each
    for (int i = 0; i < 8; i++) begin
      rnd_state = xs(rnd_state);
      pin_slow <= rnd_state[8];
      v = rnd_state[7:0] & 8'hF3;
      cyc(int'(rnd_state[11:9]));
      wr_rd(`EIL_REG_STATUS_CTRL, v, scr(0, v[1], v[0]), "random ctrl");
      pin(1);
      rchk(`EIL_REG_STATUS_CTRL, scr(1, v[1], v[0]), "random pend");
      chk("random request", 16'(!v[1]), 16'(request_out));
      wr(`EIL_REG_STATUS_CTRL, v | 8'h04);
      pin(0);
      rchk(`EIL_REG_STATUS_CTRL, scr(0, v[1], v[0]), "random clear");
    end
    $display("test random done");
    // Reset in mid-run with the pin held low in level mode
    wr(`EIL_REG_STATUS_CTRL, 8'h01);
    pin(1);
    reset_n <= 1'h0;
    cyc(3);
    #1;
    chk("request in reset", 16'h0000, 16'(request_out));
    @(posedge sys_clk);
    reset_n <= 1'h1;
    cyc(3);
    rchk(`EIL_REG_STATUS_CTRL, 8'h00, "unused after reset");
    got = got & 8'h03;
    chk("mode after reset", 16'h0000, 16'(got));
    $display("test reset mid-run done");
    end_of_test();
  end
endmodule : tb_external_interrupt_latch
